// ==== common/strap_consts.vh ====
/*
  Constants for the strap configuration latch: register offsets, field
  positions, strap defaults and codes. Assumes inclusion by bare name.
*/
`ifndef STRAP_CONSTS_VH
`define STRAP_CONSTS_VH

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define OFS_STRAP_RAW      12'h000
`define OFS_CFG_DECODED    12'h004
`define OFS_SWITCH_CTRL    12'h008
`define OFS_TIMING_PIN     12'h00C
`define OFS_INDICATOR      12'h010

// ----------------------------------------
// strap vector bit positions
// ----------------------------------------
`define STRAP_W            9
`define SB_FLOWCTL         0
`define SB_LINKUP_MODE     1
`define SB_PHY_ROLE        2
`define SB_PHY_SPEED       3
`define SB_MGMT_LO         4
`define SB_MGMT_HI         5
`define SB_STARTUP_FWD     6
`define SB_P6_LO           7
`define SB_P6_HI           8
// default level of each weak pull, bit order as above
`define STRAP_DEFAULTS     9'h07F

// ----------------------------------------
// decoded field codes
// ----------------------------------------
`define NEG_RESERVED       2'h0
`define NEG_FORCED_100HD   2'h1
`define NEG_NAND_TREE      2'h2
`define NEG_AUTO           2'h3
`define MGMT_SERIAL        2'h0
`define MGMT_I2C           2'h1
`define MGMT_SPI           2'h2
`define P6_RGMII           2'h0
`define P6_RMII            2'h1
`define P6_RESERVED        2'h2
`define P6_MII             2'h3

// ----------------------------------------
// control register fields
// ----------------------------------------
`define CTRL_START_BIT     0
`define CTRL_SOFT_RST_BIT  1
`define TP_OUT_BIT         0
`define TP_OE_BIT          1
`define TP_IN_BIT          2
`define SYNC_STAGES        2

`endif

// ==== hw/strap_config_latch.v ====
/*
  Strap configuration latch: drives strap pins as indicators after reset,
  captures their levels at reset release or soft reset, decodes the switch
  configuration, and gives software APB access plus timing pin control.
  Assumes pins arrive synchronous to core_clk and the pad applies weak pulls.
*/
// The APB interface to the registers and the address map were decided locally.
`timescale 1ns/1ns
`include "strap_consts.vh"

// Overview of operation
// - strap pins are undriven while reset is asserted
// - strap levels are captured at reset release and become configuration
// - after reset the strap pins are driven outputs
// - weak pulls give each strap its documented default
// - flow-control strap 0 disables, 1 enables flow control, default 1
// - link-up strap 0 fast link-up, 1 normal with autoneg and crossover
// - normal link-up: 01 forced 100 half, 10 nand tree, 11 autoneg
// - fast link-up: full duplex, autoneg and crossover off, split field
// - fast link-up role strap: 0 slave crossed, 1 master straight
// - fast link-up speed strap selects forced speed, gigabit both codes
// - management select: 00 serial, 01 i2c, 1x spi
// - startup strap 0 holds forwarding until start bit set
// - port 6 mode: 00 rgmii, 01 rmii, 10 reserved, 11 mii
// - timing pin input is synchronised to core_clk
// - registers can drive and sample the timing pin
// - a software reset also recaptures the straps
// - strap pins become active-low indicator outputs after reset
module strap_config_latch #(
  parameter SYNC_STAGES = `SYNC_STAGES
) (
  input  wire                 core_clk,
  input  wire                 arst_n,
  input  wire                 clk_en,
  input  wire [`STRAP_W-1:0]  strap_in,
  output reg  [`STRAP_W-1:0]  strap_out,
  output reg  [`STRAP_W-1:0]  strap_oe,
  input  wire [`STRAP_W-1:0]  indicator_on,
  input  wire                 tp_pin_in,
  output reg                  tp_pin_out,
  output reg                  tp_pin_oe,
  output reg                  tp_event,
  input  wire                 psel,
  input  wire                 penable,
  input  wire                 pwrite,
  input  wire [11:0]          paddr,
  input  wire [31:0]          pwdata,
  output reg  [31:0]          prdata,
  output reg                  pready,
  output reg                  pslverr,
  output reg                  cfg_valid,
  output reg                  flow_ctrl_en,
  output reg                  fast_linkup,
  output reg                  autoneg_en,
  output reg                  auto_mdix_en,
  output reg                  full_duplex,
  output reg                  forced_100,
  output reg                  nand_tree_mode,
  output reg                  neg_reserved,
  output reg                  gig_master,
  output reg                  gig_speed,
  output reg  [1:0]           mgmt_if_sel,
  output reg                  switch_fwd_en,
  output reg  [1:0]           p6_mode
);

  // ----------------------------------------
  // pin synchroniser and capture
  // ----------------------------------------
  reg [`STRAP_W-1:0] sync_reg [0:SYNC_STAGES-1];
  reg [`STRAP_W-1:0] strap_reg;
  reg                capture_pend_reg;
  reg                soft_rst_reg;
  reg                start_bit_reg;
  reg [1:0]          tp_ctrl_reg;
  reg [`STRAP_W-1:0] ind_mask_reg;
  reg [SYNC_STAGES-1:0] tp_sync_reg;
  reg                tp_last_reg;

  genvar g;
  generate
    for (g = 0; g < SYNC_STAGES; g = g + 1) begin : g_sync
      always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
          sync_reg[g] <= `STRAP_DEFAULTS;
        end else if (clk_en) begin
          sync_reg[g] <= (g == 0) ? strap_in : sync_reg[(g == 0) ? 0 : g-1];
        end
      end
    end
  endgenerate

  // pins float during capture window so the board pulls decide the level
  wire capturing = capture_pend_reg | soft_rst_reg;

  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      capture_pend_reg <= 1'b1;
      strap_reg        <= `STRAP_DEFAULTS;
      cfg_valid        <= 1'b0;
    end else if (clk_en) begin
      if (soft_rst_reg) begin
        // drivers are still on this cycle: float first, sample on the next edge
        capture_pend_reg <= 1'b1;
      end else if (capture_pend_reg) begin
        strap_reg        <= strap_in;
        capture_pend_reg <= 1'b0;
        cfg_valid        <= 1'b1;
      end
      // otherwise strap_reg holds its value until the next reset or soft reset
    end
  end

  // ----------------------------------------
  // pin drivers
  // ----------------------------------------
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      strap_oe  <= {`STRAP_W{1'b0}};
      strap_out <= {`STRAP_W{1'b1}};
    end else if (clk_en) begin
      strap_oe  <= capturing ? {`STRAP_W{1'b0}} : {`STRAP_W{1'b1}};
      strap_out <= ~(indicator_on & ind_mask_reg);
    end
  end

  // ----------------------------------------
  // configuration decode
  // ----------------------------------------
  wire [1:0] neg_field = {strap_reg[`SB_PHY_SPEED], strap_reg[`SB_PHY_ROLE]};
  wire       fast      = ~strap_reg[`SB_LINKUP_MODE];

  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      flow_ctrl_en   <= 1'b1;
      fast_linkup    <= 1'b0;
      autoneg_en     <= 1'b1;
      auto_mdix_en   <= 1'b1;
      full_duplex    <= 1'b1;
      forced_100     <= 1'b0;
      nand_tree_mode <= 1'b0;
      neg_reserved   <= 1'b0;
      gig_master     <= 1'b1;
      gig_speed      <= 1'b1;
      mgmt_if_sel    <= `MGMT_SPI;
      switch_fwd_en  <= 1'b0;
      p6_mode        <= `P6_RGMII;
    end else if (clk_en) begin
      flow_ctrl_en   <= strap_reg[`SB_FLOWCTL];
      fast_linkup    <= fast;
      autoneg_en     <= ~fast & (neg_field == `NEG_AUTO);
      auto_mdix_en   <= ~fast & (neg_field == `NEG_AUTO || neg_field == `NEG_FORCED_100HD);
      full_duplex    <= fast | (neg_field == `NEG_AUTO);
      forced_100     <= ~fast & (neg_field == `NEG_FORCED_100HD);
      nand_tree_mode <= ~fast & (neg_field == `NEG_NAND_TREE);
      neg_reserved   <= ~fast & (neg_field == `NEG_RESERVED);
      gig_master     <= fast ? strap_reg[`SB_PHY_ROLE] : 1'b1;
      // both speed codes read as gigabit until the encoding is confirmed
      gig_speed      <= 1'b1;
      mgmt_if_sel    <= strap_reg[`SB_MGMT_HI] ? `MGMT_SPI
                        : {1'b0, strap_reg[`SB_MGMT_LO]};
      switch_fwd_en  <= ~capturing & (strap_reg[`SB_STARTUP_FWD] | start_bit_reg);
      p6_mode        <= {strap_reg[`SB_P6_HI], strap_reg[`SB_P6_LO]};
    end
  end

  // ----------------------------------------
  // timing pin
  // ----------------------------------------
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      tp_sync_reg <= {SYNC_STAGES{1'b0}};
      tp_last_reg <= 1'b0;
      tp_event    <= 1'b0;
      tp_pin_out  <= 1'b0;
      tp_pin_oe   <= 1'b0;
    end else if (clk_en) begin
      tp_sync_reg <= {tp_sync_reg[SYNC_STAGES-2:0], tp_pin_in};
      tp_last_reg <= tp_sync_reg[SYNC_STAGES-1];
      tp_event    <= tp_sync_reg[SYNC_STAGES-1] & ~tp_last_reg;
      tp_pin_out  <= tp_ctrl_reg[`TP_OUT_BIT];
      tp_pin_oe   <= tp_ctrl_reg[`TP_OE_BIT];
    end
  end

  // ----------------------------------------
  // apb register slave
  // ----------------------------------------
  wire       acc   = psel & penable & ~pready;
  // write lands at the edge where the master samples pready high
  wire       wr    = psel & penable & pready & pwrite;
  reg [31:0] rd_next;
  reg        err_next;

  always @* begin
    rd_next  = 32'h00000000;
    err_next = 1'b0;
    case (paddr)
      `OFS_STRAP_RAW:   rd_next = {23'h000000, strap_reg};
      `OFS_CFG_DECODED: rd_next = {14'h0000, cfg_valid, p6_mode, switch_fwd_en, mgmt_if_sel,
                                   gig_speed, gig_master, neg_reserved, nand_tree_mode, forced_100,
                                   full_duplex, auto_mdix_en, autoneg_en, fast_linkup, flow_ctrl_en,
                                   2'h0};
      `OFS_SWITCH_CTRL: rd_next = {30'h00000000, soft_rst_reg, start_bit_reg};
      `OFS_TIMING_PIN:  rd_next = {29'h00000000, tp_sync_reg[SYNC_STAGES-1], tp_ctrl_reg};
      `OFS_INDICATOR:   rd_next = {23'h000000, ind_mask_reg};
      default:          err_next = 1'b1;
    endcase
  end

  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pready        <= 1'b0;
      pslverr       <= 1'b0;
      prdata        <= 32'h00000000;
      start_bit_reg <= 1'b0;
      soft_rst_reg  <= 1'b0;
      tp_ctrl_reg   <= 2'h0;
      ind_mask_reg  <= {`STRAP_W{1'b1}};
    end else if (clk_en) begin
      pready  <= acc;
      pslverr <= acc & err_next;
      prdata  <= (acc & ~pwrite) ? rd_next : 32'h00000000;
      // soft reset lasts one cycle: pins float, straps recapture
      soft_rst_reg <= 1'b0;
      if (wr && !err_next) begin
        case (paddr)
          `OFS_SWITCH_CTRL: begin
            start_bit_reg <= pwdata[`CTRL_START_BIT];
            soft_rst_reg  <= pwdata[`CTRL_SOFT_RST_BIT];
          end
          `OFS_TIMING_PIN:  tp_ctrl_reg  <= pwdata[1:0];
          `OFS_INDICATOR:   ind_mask_reg <= pwdata[`STRAP_W-1:0];
          default: ;
        endcase
      end
    end
  end

endmodule // strap_config_latch

// ==== verification/strap_board.sv ====
/* board side of the strap pins: fitted resistors or the weak pad pull
   assumes the latch enables all pin drivers together after reset */
`timescale 1ns/1ns
`include "strap_consts.vh"
module strap_board (
  input  wire [8:0] fit,
  input  wire [8:0] lvl,
  input  wire [8:0] oe,
  input  wire [8:0] drv,
  output wire [8:0] pin
);
  // unfitted pins fall back to the pad pull, never to a stale level
  assign pin = (oe & drv) | (~oe & fit & lvl) | (~oe & ~fit & `STRAP_DEFAULTS);
endmodule // strap_board

// ==== verification/strap_config_latch_assertions.sv ====
/* port assertions for the strap latch
   assumes one clock domain and the asynchronous active-low reset */
`timescale 1ns/1ns
module strap_config_latch_assertions #(
  parameter SYNC_STAGES = 2
) (
  input wire       core_clk,
  input wire       arst_n,
  input wire [8:0] strap_oe,
  input wire [8:0] strap_out,
  input wire [8:0] indicator_on,
  input wire       tp_pin_in,
  input wire       tp_event,
  input wire       psel,
  input wire       penable,
  input wire       pready,
  input wire       cfg_valid,
  input wire       fast_linkup,
  input wire       autoneg_en,
  input wire       auto_mdix_en,
  input wire       full_duplex,
  input wire       forced_100,
  input wire       gig_speed,
  input wire [1:0] mgmt_if_sel,
  input wire [1:0] p6_mode
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  wire run = strap_oe == 9'h1FF;
  oe_in_reset_a: assert property (disable iff (1'b0) !arst_n |-> strap_oe == 9'h000)
    else $error("strap pin driven in reset");
  oe_release_a: assert property ($rose(cfg_valid) |=> run)
    else $error("strap pins not driven after capture");
  valid_sticky_a: assert property (cfg_valid |=> cfg_valid)
    else $error("config valid dropped");
  cfg_hold_a: assert property (run [*3] |-> $stable({fast_linkup, mgmt_if_sel, p6_mode}))
    else $error("config changed without reset");
  fast_decode_a: assert property (run && fast_linkup |-> full_duplex && !autoneg_en && !auto_mdix_en && gig_speed)
    else $error("fast link-up decode wrong");
  forced_decode_a: assert property (run && forced_100 |-> !fast_linkup && !autoneg_en && !full_duplex && auto_mdix_en)
    else $error("forced speed decode wrong");
  mgmt_code_a: assert property (mgmt_if_sel != 2'h3)
    else $error("illegal management code");
  indicator_drive_a: assert property (run && $stable(strap_oe) && $stable(indicator_on) |-> strap_out == ~indicator_on)
    else $error("indicator level wrong");
  tp_sync_a: assert property ($rose(tp_pin_in) |-> ##[2:3] tp_event)
    else $error("timing pin event missing");
  apb_wait_a: assert property (psel && penable && !pready |=> pready)
    else $error("apb answer late");
  cover property (run && fast_linkup);
  cover property (run && forced_100);
  cover property (tp_event);
endmodule // strap_config_latch_assertions

bind strap_config_latch strap_config_latch_assertions #(.SYNC_STAGES(SYNC_STAGES)) chk (.core_clk, .arst_n,
  .strap_oe, .strap_out, .indicator_on, .tp_pin_in, .tp_event, .psel, .penable, .pready, .cfg_valid,
  .fast_linkup, .autoneg_en, .auto_mdix_en, .full_duplex, .forced_100, .gig_speed, .mgmt_if_sel, .p6_mode);

// ==== verification/tb_top.sv ====
/* bench for the strap latch: strap rows, soft reset, timing pin, apb
   assumes the apb slave answers by pready within a few cycles */
`timescale 1ns/1ns
`include "strap_consts.vh"
module tb_top;
  logic        core_clk, arst_n, psel, penable, pwrite, tp_pin_in, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, rd;
  logic [8:0]  fit, lvl, indicator_on;
  int          fail_count, checked;
  wire  [8:0]  pin, strap_out, strap_oe;
  wire  [31:0] prdata;
  wire         pready, pslverr, tp_pin_out, tp_pin_oe, cfg_valid, switch_fwd_en;
  wire  [13:0] got;
  logic [8:0]  rows [6] = '{9'h000, 9'h0B3, 9'h11A, 9'h186, 9'h06D, 9'h1CF};
  strap_board board (.fit(fit), .lvl(lvl), .oe(strap_oe), .drv(strap_out), .pin(pin));
  strap_config_latch uut (.core_clk, .arst_n, .clk_en(1'b1), .strap_in(pin), .strap_out, .strap_oe,
    .indicator_on, .tp_pin_in, .tp_pin_out, .tp_pin_oe, .tp_event(), .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .cfg_valid, .flow_ctrl_en(got[13]), .fast_linkup(got[12]),
    .autoneg_en(got[11]), .auto_mdix_en(got[10]), .full_duplex(got[9]), .forced_100(got[8]),
    .nand_tree_mode(got[7]), .neg_reserved(got[6]), .gig_master(got[5]), .gig_speed(got[4]),
    .mgmt_if_sel(got[3:2]), .switch_fwd_en, .p6_mode(got[1:0]));
  // ------------------------------
  // tasks
  // ------------------------------
  task stop_test;
    $display("%0d compares, %0d wrong", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task cmp(input logic [31:0] g, e);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge core_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge core_clk) penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
    if (n >= 20) begin
      cmp(0, 1);
      stop_test;
    end
  endtask
  // expected decode; gig speed in normal mode and autoneg, crossover and duplex for normal codes 00 and 10 are masked
  function automatic [13:0] ex(input [8:0] s);
    logic n;
    logic [1:0] p;
    n = s[1];
    p = s[3:2];
    ex = {s[0], !n, n && p == 2'h3, n, !n || p != 2'h1, n && p == 2'h1, n && p == 2'h2, n && p == 2'h0,
          s[2] | n, 1'b1, s[5] ? 2'h2 : {1'b0, s[4]}, s[8:7]};
  endfunction
  task chk(input logic [8:0] s);
    logic [13:0] m;
    m = {2'h3, {3{!s[1] || s[2]}}, 4'hF, !s[1], 4'hF};
    cmp(got & m, ex(s) & m);
    cmp(switch_fwd_en, s[6]);
    cmp(cfg_valid, 1'b1);
    apb(0, `OFS_STRAP_RAW, 0);
    cmp(rd, s);
  endtask
  task boot(input logic [8:0] f, v);
    @(posedge core_clk);
    {fit, lvl, arst_n} <= {f, v, 1'b0};
    repeat (4) @(posedge core_clk);
    cmp(strap_oe, 9'h000);
    arst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    cmp(strap_oe, 9'h1FF);
  endtask
  initial begin
    core_clk = 0;
    forever #10 core_clk = ~core_clk;
  end
  initial begin
    arst_n = 0;
    {psel, penable, pwrite, tp_pin_in, paddr, pwdata, fit, lvl, indicator_on} = '0;
    boot(9'h000, 9'h000);
    chk(`STRAP_DEFAULTS);
    $display("default test done");
    foreach (rows[i]) begin
      boot(9'h1FF, rows[i]);
      chk(rows[i]);
      $display("row %0d done", i);
    end
    @(posedge core_clk) indicator_on <= 9'h1FF;
    repeat (3) @(posedge core_clk);
    cmp(strap_out, 9'h000);
    chk(9'h1CF);
    boot(9'h1FF, 9'h000);
    apb(1, `OFS_SWITCH_CTRL, 32'h1);
    repeat (2) @(posedge core_clk);
    cmp(switch_fwd_en, 1'b1);
    lvl <= 9'h06D;
    apb(1, `OFS_SWITCH_CTRL, 32'h2);
    repeat (4) @(posedge core_clk);
    chk(9'h06D);
    apb(1, `OFS_TIMING_PIN, 32'h3);
    repeat (2) @(posedge core_clk);
    cmp({tp_pin_oe, tp_pin_out}, 2'h3);
    tp_pin_in <= 1'b1;
    repeat (5) @(posedge core_clk);
    apb(0, `OFS_TIMING_PIN, 0);
    cmp(rd[2], 1'b1);
    apb(0, 12'h014, 0);
    cmp(err, 1'b1);
    cmp(rd, 0);
    $display("hand tests done");
    stop_test;
  end
endmodule // tb_top
